// [logic/strap_flags_cfg.svh]
// Summary of operation
// - While the disable input is low the block sits in reset and shutdown, and it runs normally while that input is high.
// - The block enters I2C configuration mode when both I2C pins are high at reset release, and otherwise uses pin-strap mode.
// - In I2C mode the block answers as an I2C target at 7-bit address 0x2C, and the outside controller must use that address.
// - In strap mode after reset the I2C clock pin drives the attach flag, which rises from the unconnected state when a line pull-up is seen.
// - The attach flag is cleared when a disconnect of the USB device is detected.
// - The AC-boost strap is captured at the moment the disable input is released.
// - Once captured, the AC-boost setting holds and ignores the strap pin until the next reset.
// - A floating AC-boost strap selects the maximum AC-boost setting.
// - In strap mode the Strap_a pin is read as a three-level input at reset, high giving 80 mV and pulled low giving 40 mV.
// - In strap mode after reset the Strap_a pin becomes an output flag showing high-speed operation.
// - The high-speed flag rises after a compliance test fixture is seen from the unconnected state and is followed by the test packet.
// - The high-speed flag also rises on squelch after a USB reset whose handshake had one chirp J and chirp K pair each lasting 18 us to 128 us.
// - In I2C mode the Strap_a pin is reserved, and in strap mode the I2C data pin is reserved.
// - The core regulator is enabled only while the channel runs in high-speed mode.
`ifndef STRAP_FLAGS_CFG_SVH
`define STRAP_FLAGS_CFG_SVH

// ==========================================================
// timing
`define CLK_PERIOD_NS 40
`define CHIRP_MIN_NS 18000
`define CHIRP_MAX_NS 128000
// least time rounds up, longest time rounds down
`define CHIRP_MIN_CYC ((`CHIRP_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CHIRP_MAX_CYC (`CHIRP_MAX_NS / `CLK_PERIOD_NS)
`define CHIRP_CNT_W 12

// ==========================================================
// fixed values and reset values
`define I2C_TARGET_ADDR 7'h2c
`define AC_BOOST_MAX 2'h3
`define AC_BOOST_RST 2'h3
`define MODE_I2C_RST 1'b0

`endif

// [logic/strap_flags_pkg.sv]
package strap_flags_pkg;

   // three-level strap pin as seen by the level comparators
   typedef enum logic [1:0] {
      LVL_LOW = 2'h0,
      LVL_MID = 2'h1,
      LVL_HIGH = 2'h2
   } pin_level_t;

   // strap_a selection; mid is the unstrapped default
   typedef enum logic [1:0] {
      STRAP_A_40MV = 2'h0,
      STRAP_A_60MV = 2'h1,
      STRAP_A_80MV = 2'h2
   } strap_a_t;

   // high-speed detection, gray along the usual path
   typedef enum logic [2:0] {
      HS_IDLE = 3'h0,
      HS_RESET = 3'h1,
      HS_GOT_J = 3'h3,
      HS_SHAKE_OK = 3'h2,
      HS_ACTIVE = 3'h6,
      HS_FIXTURE = 3'h4
   } hs_state_t;

   // one-cycle events and levels from the analog line detectors
   typedef struct packed {
      logic pullup_seen;
      logic disconnect_seen;
      logic fixture_seen;
      logic test_packet_seen;
      logic usb_reset_seen;
      logic chirp_j;
      logic chirp_k;
      logic squelch_seen;
   } line_events_t;

endpackage : strap_flags_pkg

// [logic/chirp_timer.sv]
`timescale 1ns/100ps
`default_nettype none
`include "strap_flags_cfg.svh"

module chirp_timer #(
   parameter int unsigned MIN_CYC = `CHIRP_MIN_CYC,
   parameter int unsigned MAX_CYC = `CHIRP_MAX_CYC,
   parameter int unsigned CNT_W = `CHIRP_CNT_W
)(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic chirp_level,
   output logic good_pulse,
   output logic bad_pulse
);
   localparam logic [CNT_W-1:0] MIN_C = CNT_W'(MIN_CYC);
   localparam logic [CNT_W-1:0] MAX_C = CNT_W'(MAX_CYC);
   localparam logic [CNT_W-1:0] SAT_C = {CNT_W{1'b1}};

   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic level_q, level_d;
   logic good_q, good_d;
   logic bad_q, bad_d;
   logic ends;

   // ==========================================================
   // chirp length measure
   // counter saturates so an endless chirp still reads as too long
   always_comb
   begin
      ends = level_q && !chirp_level;
      level_d = chirp_level;
      cnt_d = '0;
      if (chirp_level)
      begin
         cnt_d = (cnt_q == SAT_C) ? cnt_q : cnt_q + 1'b1;
      end
      good_d = ends && (cnt_q >= MIN_C) && (cnt_q <= MAX_C);
      bad_d = ends && !((cnt_q >= MIN_C) && (cnt_q <= MAX_C));
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         cnt_q <= '0;
         level_q <= 1'b0;
         good_q <= 1'b0;
         bad_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         level_q <= level_d;
         good_q <= good_d;
         bad_q <= bad_d;
      end
   end

   assign good_pulse = good_q;
   assign bad_pulse = bad_q;

   // ==========================================================
   // checks
   property p_chirp_window;
      @(posedge ref_clk) disable iff (reset)
      good_q |-> ($past(cnt_q) >= MIN_C) && ($past(cnt_q) <= MAX_C);
   endproperty
   a_chirp_window: assert property (p_chirp_window)
      else $error("chirp accepted outside its length window");

endmodule : chirp_timer
`default_nettype wire

// [logic/strap_mode_link_flags.sv]
`timescale 1ns/100ps
`default_nettype none
`include "strap_flags_cfg.svh"

module strap_mode_link_flags (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic active_low_disable,
   input wire logic i2c_data_in,
   input wire logic i2c_clock_in,
   input wire logic [1:0] ac_boost_strap,
   input wire logic ac_boost_floating,
   input wire strap_flags_pkg::pin_level_t strap_a_level,
   input wire strap_flags_pkg::line_events_t line_events,
   output logic shutdown,
   output logic i2c_mode,
   output logic [6:0] i2c_target_address,
   output logic [1:0] ac_boost_sel,
   output strap_flags_pkg::strap_a_t strap_a_sel,
   output logic attach_detect_flag,
   output logic attach_detect_flag_oe,
   output logic high_speed_active_flag,
   output logic high_speed_active_flag_oe,
   output logic core_regulator_output
);
   import strap_flags_pkg::*;
   // every check below runs on the one clock and sleeps in reset
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);

   logic run_q, run_d;
   logic capture;
   logic mode_i2c_q, mode_i2c_d;
   logic [1:0] ac_q, ac_d;
   strap_a_t dc_q, dc_d;
   logic [6:0] addr_q, addr_d;
   logic attach_q, attach_d;
   logic attach_oe_q, attach_oe_d;
   logic hs_flag_q, hs_flag_d;
   logic hs_oe_q, hs_oe_d;
   logic reg_en_q, reg_en_d;
   logic shut_q, shut_d;
   hs_state_t st_q, st_d;
   logic j_good, j_bad, k_good, k_bad;

   // ==========================================================
   // chirp length checkers
   chirp_timer #(
      .MIN_CYC(`CHIRP_MIN_CYC),
      .MAX_CYC(`CHIRP_MAX_CYC),
      .CNT_W(`CHIRP_CNT_W)
   ) u_chirp_j (
      .ref_clk(ref_clk),
      .reset(reset),
      .chirp_level(line_events.chirp_j),
      .good_pulse(j_good),
      .bad_pulse(j_bad)
   );

   chirp_timer #(
      .MIN_CYC(`CHIRP_MIN_CYC),
      .MAX_CYC(`CHIRP_MAX_CYC),
      .CNT_W(`CHIRP_CNT_W)
   ) u_chirp_k (
      .ref_clk(ref_clk),
      .reset(reset),
      .chirp_level(line_events.chirp_k),
      .good_pulse(k_good),
      .bad_pulse(k_bad)
   );

   // ==========================================================
   // disable input and strap capture
   // straps are caught in the first cycle the disable input is high,
   // so a glitch on the pins later on cannot move the settings
   always_comb
   begin
      capture = active_low_disable && !run_q;
      run_d = active_low_disable;
      shut_d = !active_low_disable;
      mode_i2c_d = mode_i2c_q;
      ac_d = ac_q;
      dc_d = dc_q;
      addr_d = addr_q;
      if (!active_low_disable)
      begin
         // held values drop only when disabled again
         mode_i2c_d = `MODE_I2C_RST;
         ac_d = `AC_BOOST_RST;
         dc_d = STRAP_A_60MV;
         addr_d = `I2C_TARGET_ADDR;
      end
      else if (capture)
      begin
         mode_i2c_d = i2c_data_in && i2c_clock_in;
         addr_d = `I2C_TARGET_ADDR;
         ac_d = ac_boost_floating ? `AC_BOOST_MAX : ac_boost_strap;
         // in i2c mode the pin is reserved; mid level keeps the default too
         dc_d = STRAP_A_60MV;
         if (!mode_i2c_d && strap_a_level == LVL_HIGH)
         begin
            dc_d = STRAP_A_80MV;
         end
         if (!mode_i2c_d && strap_a_level == LVL_LOW)
         begin
            dc_d = STRAP_A_40MV;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         run_q <= 1'b0;
         shut_q <= 1'b1;
         mode_i2c_q <= `MODE_I2C_RST;
         ac_q <= `AC_BOOST_RST;
         dc_q <= STRAP_A_60MV;
         addr_q <= `I2C_TARGET_ADDR;
      end
      else
      begin
         run_q <= run_d;
         shut_q <= shut_d;
         mode_i2c_q <= mode_i2c_d;
         ac_q <= ac_d;
         dc_q <= dc_d;
         addr_q <= addr_d;
      end
   end

   // ==========================================================
   // attach detection and high-speed handshake tracking
   // a disconnect beats every other event in the same cycle
   always_comb
   begin
      attach_d = attach_q;
      st_d = st_q;
      if (!run_q || !active_low_disable || line_events.disconnect_seen)
      begin
         attach_d = 1'b0;
         st_d = HS_IDLE;
      end
      else
      begin
         attach_d = attach_q || line_events.pullup_seen;
         case (st_q)
            HS_IDLE:
               if (line_events.fixture_seen && !attach_q)
                  st_d = HS_FIXTURE;
               else if (line_events.usb_reset_seen)
                  st_d = HS_RESET;
            HS_FIXTURE:
               if (line_events.test_packet_seen)
                  st_d = HS_ACTIVE;
            HS_RESET:
               if (j_good)
                  st_d = HS_GOT_J;
               else if (j_bad || k_good || k_bad)
                  st_d = HS_IDLE;
            HS_GOT_J:
               if (k_good)
                  st_d = HS_SHAKE_OK;
               else if (j_good || j_bad || k_bad)
                  st_d = HS_IDLE;
            HS_SHAKE_OK:
               if (line_events.squelch_seen)
                  st_d = HS_ACTIVE;
               else if (j_good || j_bad || k_good || k_bad)
                  st_d = HS_IDLE; // a second pair is no single handshake
            HS_ACTIVE:
               if (line_events.usb_reset_seen)
                  st_d = HS_RESET;
            default:
               st_d = HS_IDLE;
         endcase
      end
   end

   // ==========================================================
   // pin flags and regulator enable
   // flags only drive their pins in strap mode while running
   always_comb
   begin
      hs_flag_d = (st_d == HS_ACTIVE);
      reg_en_d = (st_d == HS_ACTIVE);
      attach_oe_d = run_d && !mode_i2c_d;
      hs_oe_d = run_d && !mode_i2c_d;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         attach_q <= 1'b0;
         st_q <= HS_IDLE;
         hs_flag_q <= 1'b0;
         reg_en_q <= 1'b0;
         attach_oe_q <= 1'b0;
         hs_oe_q <= 1'b0;
      end
      else
      begin
         attach_q <= attach_d;
         st_q <= st_d;
         hs_flag_q <= hs_flag_d;
         reg_en_q <= reg_en_d;
         attach_oe_q <= attach_oe_d;
         hs_oe_q <= hs_oe_d;
      end
   end

   assign shutdown = shut_q;
   assign i2c_mode = mode_i2c_q;
   assign i2c_target_address = addr_q;
   assign ac_boost_sel = ac_q;
   assign strap_a_sel = dc_q;
   assign attach_detect_flag = attach_q;
   assign attach_detect_flag_oe = attach_oe_q;
   assign high_speed_active_flag = hs_flag_q;
   assign high_speed_active_flag_oe = hs_oe_q;
   assign core_regulator_output = reg_en_q;

   // ==========================================================
   // checks
   property p_disable_shuts;
      !active_low_disable |=> shut_q && !hs_flag_q && !attach_q;
   endproperty
   a_disable_shuts: assert property (p_disable_shuts)
      else $error("block not shut down while disabled");
   property p_mode_capture;
      capture |=> mode_i2c_q == $past(i2c_data_in && i2c_clock_in);
   endproperty
   a_mode_capture: assert property (p_mode_capture)
      else $error("mode not taken from the i2c pins at release");
   property p_address;
      run_q |-> addr_q == `I2C_TARGET_ADDR;
   endproperty
   a_address: assert property (p_address)
      else $error("wrong i2c target address");
   property p_attach_set;
      run_q && active_low_disable && line_events.pullup_seen
         && !line_events.disconnect_seen |=> attach_q [*1] ##1 1'b1;
   endproperty
   a_attach_set: assert property (p_attach_set)
      else $error("attach flag missed a pull-up");
   property p_attach_clear;
      line_events.disconnect_seen |=> !attach_q && st_q == HS_IDLE;
   endproperty
   a_attach_clear: assert property (p_attach_clear)
      else $error("attach flag kept after disconnect");
   property p_ac_hold;
      run_q && active_low_disable |=> $stable(ac_q);
   endproperty
   a_ac_hold: assert property (p_ac_hold)
      else $error("ac boost moved after capture");
   property p_ac_float;
      capture && ac_boost_floating |=> ac_q == `AC_BOOST_MAX ##1 run_q;
   endproperty
   a_ac_float: assert property (p_ac_float)
      else $error("floating strap did not give maximum ac boost");
   property p_dc_high;
      capture && !(i2c_data_in && i2c_clock_in)
         && strap_a_level == LVL_HIGH |=> dc_q == STRAP_A_80MV;
   endproperty
   a_dc_high: assert property (p_dc_high)
      else $error("high dc strap not read as 80 mV");
   property p_strap_reserved;
      mode_i2c_q |-> !hs_oe_q && !attach_oe_q;
   endproperty
   a_strap_reserved: assert property (p_strap_reserved)
      else $error("strap pins driven in i2c mode");
   property p_fixture_hs;
      st_q == HS_FIXTURE && line_events.test_packet_seen && active_low_disable
         && !line_events.disconnect_seen |=> hs_flag_q;
   endproperty
   a_fixture_hs: assert property (p_fixture_hs)
      else $error("test packet after fixture did not raise hs flag");
   property p_squelch_hs;
      st_q == HS_SHAKE_OK && line_events.squelch_seen && active_low_disable
         && !line_events.disconnect_seen |=> hs_flag_q;
   endproperty
   a_squelch_hs: assert property (p_squelch_hs)
      else $error("squelch after handshake did not raise hs flag");
   property p_regulator;
      (reg_en_q == hs_flag_q) and (hs_flag_q |-> st_q == HS_ACTIVE);
   endproperty
   a_regulator: assert property (p_regulator)
      else $error("regulator enable not tied to high-speed mode");

endmodule : strap_mode_link_flags
`default_nettype wire

// [test/usb_far_end.sv]
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// far-end line model: cable partner seen through the detectors
module usb_far_end
   import strap_flags_pkg::*;
(
   input wire logic ref_clk,
   output var strap_flags_pkg::line_events_t line_events
);
   import strap_flags_pkg::*;

   // quiet lines until the bench asks for activity
   initial line_events = '0;

   // one-cycle detector pulse, raised just after an edge
   task automatic pulse(input logic [7:0] bits);
      @(posedge ref_clk);
      line_events <= line_events_t'(bits);
      @(posedge ref_clk);
      line_events <= '0;
   endtask : pulse

   // chirp level held for len cycles; bench picks good and bad lengths
   task automatic chirp(input logic is_k, input int len);
      @(posedge ref_clk);
      if (is_k)
         line_events.chirp_k <= 1'b1;
      else
         line_events.chirp_j <= 1'b1;
      repeat (len) @(posedge ref_clk);
      line_events <= '0;
   endtask : chirp
endmodule : usb_far_end

`default_nettype wire

// [test/test_strap_mode_link_flags.sv]
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// top of the bench
module test_strap_mode_link_flags;
   import strap_flags_pkg::*;

   localparam logic [7:0] PU = 8'h80;
   localparam logic [7:0] DC = 8'h40;
   localparam logic [7:0] FX = 8'h20;
   localparam logic [7:0] TP = 8'h10;
   localparam logic [7:0] UR = 8'h08;
   localparam logic [7:0] SQ = 8'h01;

   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic active_low_disable = 1'b0;
   logic i2c_data_in = 1'b0;
   logic i2c_clock_in = 1'b0;
   logic [1:0] ac_boost_strap = 2'h0;
   logic ac_boost_floating = 1'b0;
   pin_level_t strap_a_level = LVL_MID;
   line_events_t line_events;
   logic shutdown, i2c_mode, att, att_oe, hs, hs_oe, core_regulator_output_en;
   logic [6:0] addr;
   logic [1:0] ac_sel;
   strap_a_t dc_sel;
   logic [17:0] obs, note;
   logic [17:0] exp_q[$];
   logic cur_run = 1'b0;
   logic cur_mode = 1'b0;
   logic [1:0] cur_ac = 2'h3;
   strap_a_t cur_dc = STRAP_A_60MV;
   int bad_count = 0;
   int compares = 0;
   int jl[4] = '{449, 500, 500, 450};
   int kl[4] = '{500, 3201, 500, 3200};

   strap_mode_link_flags strap_mode_link_flags_i (
      .ref_clk(ref_clk), .reset(reset),
      .active_low_disable(active_low_disable),
      .i2c_data_in(i2c_data_in), .i2c_clock_in(i2c_clock_in),
      .ac_boost_strap(ac_boost_strap),
      .ac_boost_floating(ac_boost_floating),
      .strap_a_level(strap_a_level), .line_events(line_events),
      .shutdown(shutdown), .i2c_mode(i2c_mode),
      .i2c_target_address(addr), .ac_boost_sel(ac_sel),
      .strap_a_sel(dc_sel), .attach_detect_flag(att),
      .attach_detect_flag_oe(att_oe), .high_speed_active_flag(hs),
      .high_speed_active_flag_oe(hs_oe),
      .core_regulator_output(core_regulator_output_en)
   );

   usb_far_end usb_far_end_i (
      .ref_clk(ref_clk),
      .line_events(line_events)
   );

   // 25 MHz
   always #20 ref_clk = ~ref_clk;

   assign obs = {shutdown, i2c_mode, addr, ac_sel, dc_sel, att, att_oe,
      hs, hs_oe, core_regulator_output_en};

   // monitor: oldest note against outputs settled since the last edge
   always @(negedge ref_clk)
   begin
      if (exp_q.size() > 0)
      begin
         note = exp_q.pop_front();
         compares++;
         if (obs !== note)
         begin
            bad_count++;
            $display("mismatch t=%0t exp=%h got=%h", $time, note, obs);
         end
      end
   end

   // ==========================================================
   // driver helpers
   // note the whole output picture; regulator follows the hs flag
   task automatic expect_out(input logic a, input logic h);
      if (cur_run)
         exp_q.push_back({1'b0, cur_mode, 7'h2c, cur_ac, cur_dc, a,
            ~cur_mode, h, ~cur_mode, h});
      else
         exp_q.push_back({1'b1, 1'b0, 7'h2c, 2'h3, STRAP_A_60MV, 5'h00});
   endtask : expect_out

   // release with straps set, then wander straps to prove they are held
   task automatic release_run(input logic sda, input logic scl,
      input logic [1:0] ac, input logic flt, input pin_level_t lvl);
      @(posedge ref_clk);
      i2c_data_in <= sda;
      i2c_clock_in <= scl;
      ac_boost_strap <= ac;
      ac_boost_floating <= flt;
      strap_a_level <= lvl;
      active_low_disable <= 1'b1;
      cur_mode = sda & scl;
      cur_ac = flt ? 2'h3 : ac;
      cur_dc = cur_mode ? STRAP_A_60MV : (lvl == LVL_HIGH ? STRAP_A_80MV
         : (lvl == LVL_LOW ? STRAP_A_40MV : STRAP_A_60MV));
      repeat (3) @(posedge ref_clk);
      cur_run = 1'b1;
      expect_out(1'b0, 1'b0);
      ac_boost_strap <= ~ac;
      ac_boost_floating <= ~flt;
      strap_a_level <= (lvl == LVL_HIGH) ? LVL_LOW : LVL_HIGH;
      i2c_data_in <= ~sda;
      i2c_clock_in <= ~scl;
      repeat (4) @(posedge ref_clk);
      expect_out(1'b0, 1'b0);
   endtask : release_run

   // drive the disable low; held values and flags fall away
   task automatic disable_run();
      @(posedge ref_clk);
      active_low_disable <= 1'b0;
      repeat (2) @(posedge ref_clk);
      cur_run = 1'b0;
      expect_out(1'b0, 1'b0);
   endtask : disable_run

   task automatic stop_test();
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test

   // watchdog: the sequence needs about 9500 cycles
   initial
   begin
      repeat (40000) @(posedge ref_clk);
      bad_count++;
      stop_test();
   end

   // ==========================================================
   // main sequence
   initial
   begin
      void'($urandom(32'heed2));
      // disable held low through reset, as an outside driver must
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      expect_out(1'b0, 1'b0);
      // every ac code, floating or not, random mode and dc level
      for (int i = 0; i < 8; i++)
      begin
         release_run((i == 5) || ($urandom_range(1, 0) == 1),
            (i == 5) || ($urandom_range(1, 0) == 1), i[1:0], i[2],
            pin_level_t'($urandom_range(2, 0)));
         disable_run();
      end
      release_run(1'b0, 1'b0, 2'h1, 1'b0, LVL_HIGH);
      // attach and detach; disconnect wins a tie
      usb_far_end_i.pulse(PU);
      expect_out(1'b1, 1'b0);
      usb_far_end_i.pulse(PU | DC);
      expect_out(1'b0, 1'b0);
      // fixture then test packet from the unconnected state
      usb_far_end_i.pulse(FX);
      expect_out(1'b0, 1'b0);
      usb_far_end_i.pulse(TP);
      expect_out(1'b0, 1'b1);
      usb_far_end_i.pulse(DC);
      expect_out(1'b0, 1'b0);
      // fixture while attached does not count
      usb_far_end_i.pulse(PU);
      usb_far_end_i.pulse(FX);
      usb_far_end_i.pulse(TP);
      expect_out(1'b1, 1'b0);
      usb_far_end_i.pulse(DC);
      // handshakes: short j, long k, k first, then both at the limits
      for (int i = 0; i < 4; i++)
      begin
         usb_far_end_i.pulse(UR);
         usb_far_end_i.chirp(i == 2, jl[i]);
         usb_far_end_i.chirp(i != 2, kl[i]);
         repeat (2) @(posedge ref_clk);
         usb_far_end_i.pulse(SQ);
         expect_out(1'b0, i == 3);
      end
      // a new usb reset drops the flag
      usb_far_end_i.pulse(UR);
      expect_out(1'b0, 1'b0);
      // a fixture only counts from the idle, unconnected state
      usb_far_end_i.pulse(DC);
      usb_far_end_i.pulse(FX);
      usb_far_end_i.pulse(TP);
      expect_out(1'b0, 1'b1);
      disable_run();
      repeat (2) @(negedge ref_clk);
      stop_test();
   end
endmodule : test_strap_mode_link_flags

`default_nettype wire
